//--- hw/mode_status.v
// The implementer's own choice: the strobed register port.
`timescale 1ns/1ns
`include "mode_status_consts.vh"
module mode_status (
	input  wire        CLK,
	input  wire        RESETN,
	input  wire [4:0]  ADDR,
	input  wire [15:0] WDATA,
	input  wire        WR,
	input  wire        RD,
	output reg  [15:0] RDATA,
	input  wire        LINK_CODE_OK,
	input  wire        LP_RFAULT_IN,
	input  wire        FAR_FAULT,
	input  wire        MGMT_PREAMBLE_SEEN,
	output reg         MGMT_FRAME_ACCEPT,
	output reg         IRQ
);
	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	wire link_ok_s;
	wire lp_rf_s;
	wire far_s;
	wire pre_s;
	sync2 u_s0 (.clk(CLK), .resetn(RESETN), .d(LINK_CODE_OK),       .q(link_ok_s));
	sync2 u_s1 (.clk(CLK), .resetn(RESETN), .d(LP_RFAULT_IN),       .q(lp_rf_s));
	sync2 u_s2 (.clk(CLK), .resetn(RESETN), .d(FAR_FAULT),          .q(far_s));
	sync2 u_s3 (.clk(CLK), .resetn(RESETN), .d(MGMT_PREAMBLE_SEEN), .q(pre_s));

	function hit;
		input [4:0] a;
		input [4:0] ofs;
		begin
			hit = (a == ofs);
		end
	endfunction

	// ----------------------------------------
	// Control registers
	// ----------------------------------------
	reg [15:0] advert_r;
	reg [15:0] partner_r;
	reg [15:0] expansion_r;
	reg [15:0] pcs_cfg_r;
	reg [15:0] an_ctrl_r;
	reg [1:0]  irq_stat_r;
	reg [1:0]  irq_mask_r;
	reg        an_done_r;
	reg        rfault_r;
	reg [7:0]  an_cnt_r;
	reg        an_busy_r;

	wire an_en  = an_ctrl_r[`B_AN_ENABLE];
	wire wr_adv = WR && hit(ADDR, `OFS_ADVERT);
	wire wr_an  = WR && hit(ADDR, `OFS_AN_CTRL);
	wire restart = wr_adv || (wr_an && WDATA[`B_AN_RESTART]);

	// ----------------------------------------
	// Negotiation progress
	// ----------------------------------------
	// Completion requires a full window of stable link code, so the
	// partner and expansion words are captured before the flag rises.
	wire an_finish = an_busy_r && link_ok_s && (an_cnt_r == 8'h00);

	always @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			advert_r    <= `RST_ADVERT;
			pcs_cfg_r   <= `RST_PCS_CFG;
			an_ctrl_r   <= `RST_AN_CTRL;
			partner_r   <= 16'h0000;
			expansion_r <= 16'h0000;
			an_done_r   <= 1'b0;
			an_busy_r   <= 1'b1;
			an_cnt_r    <= `AN_CYCLES;
		end else begin
			if (wr_adv)
				advert_r <= WDATA;
			if (WR && hit(ADDR, `OFS_PCS_CFG))
				pcs_cfg_r <= WDATA;
			if (wr_an)
				an_ctrl_r <= {WDATA[15:2], 1'b0, WDATA[0]};
			if (restart || !an_en) begin
				an_done_r <= 1'b0;
				an_busy_r <= an_en || (wr_an && WDATA[`B_AN_ENABLE]);
				an_cnt_r  <= `AN_CYCLES;
			end else if (an_busy_r) begin
				if (!link_ok_s)
					an_cnt_r <= `AN_CYCLES;
				else if (an_cnt_r != 8'h00)
					an_cnt_r <= an_cnt_r - 8'h01;
				partner_r <= {2'h0, lp_rf_s, 13'h0001};
				expansion_r <= 16'h0001;
				if (an_finish) begin
					an_busy_r <= 1'b0;
					an_done_r <= 1'b1;
				end
			end
		end
	end

	// ----------------------------------------
	// Remote fault
	// ----------------------------------------
	wire rf_src = an_en ? (an_done_r && partner_r[`B_LP_RFAULT])
	                    : far_s;
	wire rd_stat = RD && hit(ADDR, `OFS_STATUS);

	always @(posedge CLK or negedge RESETN) begin
		if (!RESETN)
			rfault_r <= 1'b0;
		else if (rf_src)
			rfault_r <= 1'b1;
		else if (rd_stat)
			rfault_r <= 1'b0;
	end

	// ----------------------------------------
	// Status word
	// ----------------------------------------
	wire [15:0] status_w;
	assign status_w[`B_T4]      = 1'b0;
	assign status_w[`B_100FD]   = advert_r[`B_ADV_100FD];
	assign status_w[`B_100HD]   = advert_r[`B_ADV_100HD];
	assign status_w[`B_10FD]    = advert_r[`B_ADV_10FD];
	assign status_w[`B_10HD]    = advert_r[`B_ADV_10HD];
	assign status_w[10:7]       = 4'h0;
	assign status_w[`B_PRE_OPT] = ~pcs_cfg_r[`B_PCS_PRE_EN];
	assign status_w[`B_AN_DONE] = an_done_r;
	assign status_w[`B_RFAULT]  = rfault_r;
	assign status_w[3:0]        = 4'h0;

	// Optional flag high means preamble may be skipped.
	wire mgmt_preamble_optional_flag = status_w[`B_PRE_OPT];

	// ----------------------------------------
	// Interrupts
	// ----------------------------------------
	reg an_done_d_r;
	reg rfault_d_r;
	wire [1:0] ev = {rfault_r & ~rfault_d_r, an_done_r & ~an_done_d_r};
	wire wr_is = WR && hit(ADDR, `OFS_IRQ_STATUS);

	always @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			an_done_d_r <= 1'b0;
			rfault_d_r  <= 1'b0;
			irq_stat_r  <= `RST_IRQ;
			irq_mask_r  <= `RST_IRQ;
			IRQ         <= 1'b0;
		end else begin
			an_done_d_r <= an_done_r;
			rfault_d_r  <= rfault_r;
			irq_stat_r  <= ev | (irq_stat_r & ~(wr_is ? WDATA[1:0] : 2'h0));
			if (WR && hit(ADDR, `OFS_IRQ_MASK))
				irq_mask_r <= WDATA[1:0];
			IRQ <= |(irq_stat_r & irq_mask_r);
		end
	end

	// ----------------------------------------
	// Management frame gate
	// ----------------------------------------
	always @(posedge CLK or negedge RESETN) begin
		if (!RESETN)
			MGMT_FRAME_ACCEPT <= 1'b0;
		else
			MGMT_FRAME_ACCEPT <= mgmt_preamble_optional_flag | pre_s;
	end

	// ----------------------------------------
	// Read port
	// ----------------------------------------
	// Status offset decodes writes as nothing at all.
	always @(posedge CLK or negedge RESETN) begin
		if (!RESETN)
			RDATA <= 16'h0000;
		else if (RD) begin
			case (ADDR)
			`OFS_STATUS:     RDATA <= status_w;
			`OFS_ADVERT:     RDATA <= advert_r;
			`OFS_PARTNER:    RDATA <= partner_r;
			`OFS_EXPANSION:  RDATA <= expansion_r;
			`OFS_PCS_CFG:    RDATA <= pcs_cfg_r;
			`OFS_IRQ_STATUS: RDATA <= {14'h0000, irq_stat_r};
			`OFS_IRQ_MASK:   RDATA <= {14'h0000, irq_mask_r};
			`OFS_AN_CTRL:    RDATA <= an_ctrl_r;
			default:         RDATA <= 16'h0000;
			endcase
		end else
			RDATA <= 16'h0000;
	end
endmodule // mode_status

//--- hw/mode_status_consts.vh
`ifndef MODE_STATUS_CONSTS_VH
`define MODE_STATUS_CONSTS_VH
// ----------------------------------------
// Register map
// ----------------------------------------
`define OFS_ADVERT        5'h04
`define OFS_PARTNER       5'h05
`define OFS_EXPANSION     5'h06
`define OFS_STATUS        5'h01
`define OFS_PCS_CFG       5'h17
`define OFS_IRQ_STATUS    5'h18
`define OFS_IRQ_MASK      5'h19
`define OFS_AN_CTRL       5'h1a
// ----------------------------------------
// Field positions
// ----------------------------------------
`define B_T4              15
`define B_100FD           14
`define B_100HD           13
`define B_10FD            12
`define B_10HD            11
`define B_PRE_OPT         6
`define B_AN_DONE         5
`define B_RFAULT          4
`define B_ADV_100FD       8
`define B_ADV_100HD       7
`define B_ADV_10FD        6
`define B_ADV_10HD        5
`define B_LP_RFAULT       13
`define B_PCS_PRE_EN      5
`define B_AN_ENABLE       0
`define B_AN_RESTART      1
`define IRQ_AN_DONE       0
`define IRQ_RFAULT        1
// ----------------------------------------
// Reset values
// ----------------------------------------
`define RST_ADVERT        16'h01e1
`define RST_PCS_CFG       16'h0000
`define RST_AN_CTRL       16'h0001
`define RST_IRQ           2'h0
// ----------------------------------------
// Timing
// ----------------------------------------
// Stable link code window, 1000 ns at 8 ns per cycle
`define AN_CYCLES         8'h7d
`endif

//--- hw/sync2.v
`timescale 1ns/1ns
module sync2 (
	input  wire clk,
	input  wire resetn,
	input  wire d,
	output reg  q
);
	reg meta_r;
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			meta_r <= 1'b0;
			q      <= 1'b0;
		end else begin
			meta_r <= d;
			q      <= meta_r;
		end
	end
endmodule // sync2

//--- sim/mode_status_checker.sv
`timescale 1ns/1ns
module mode_status_checker (
	input logic        CLK,
	input logic        RESETN,
	input logic [4:0]  ADDR,
	input logic [15:0] WDATA,
	input logic        WR,
	input logic        RD,
	input logic [15:0] RDATA,
	input logic        MGMT_PREAMBLE_SEEN,
	input logic        MGMT_FRAME_ACCEPT
);
	// ----------------------------------------
	// Status port properties
	// ----------------------------------------
	default clocking @(posedge CLK); endclocking
	default disable iff (!RESETN);
	logic [7:0] age_r;
	wire        st = RD && ADDR == 5'h01;
	// Negotiation cannot finish this soon after reset
	always_ff @(posedge CLK or negedge RESETN)
		if (!RESETN)
			age_r <= 8'h0;
		else if (age_r != 8'hff)
			age_r <= age_r + 8'h1;
	a_rdata_idle: assert property (!$past(RD) |-> RDATA == 16'h0) else $error("rdata not idle");
	a_no_t4: assert property (st |=> !RDATA[15]) else $error("bit 15 set");
	a_resv_zero: assert property (st |=> RDATA[10:7] == 4'h0) else $error("reserved set");
	a_cap_mirror: assert property (WR && ADDR == 5'h04 ##1 st |=>
		RDATA[14:11] == $past(WDATA[8:5], 2)) else $error("caps not mirrored");
	a_write_ign: assert property (st ##1 WR && ADDR == 5'h01 ##1 st |=>
		RDATA[15:6] == $past(RDATA[15:6], 2)) else $error("status written");
	// Two synchroniser stages and the output register lie between pin and gate
	a_accept_seen: assert property (MGMT_PREAMBLE_SEEN[*3] |=> MGMT_FRAME_ACCEPT) else $error("no accept");
	a_accept_need: assert property ((!MGMT_PREAMBLE_SEEN)[*2] ##0 st ##1 !RDATA[6] |=>
		!MGMT_FRAME_ACCEPT) else $error("accept without preamble");
	a_done_early: assert property (st && age_r < 8'd100 |=> !RDATA[5]) else $error("done early");
endmodule // mode_status_checker
bind mode_status mode_status_checker chk (.CLK, .RESETN, .ADDR, .WDATA, .WR, .RD, .RDATA,
	.MGMT_PREAMBLE_SEEN, .MGMT_FRAME_ACCEPT);

//--- sim/tb_top.sv
`timescale 1ns/1ns
module tb_top;
	logic        CLK = 0, RESETN = 0, WR = 0, RD = 0, LINK_CODE_OK = 0;
	logic        LP_RFAULT_IN = 0, FAR_FAULT = 0, MGMT_PREAMBLE_SEEN = 0;
	logic [4:0]  ADDR = 5'h0;
	logic [15:0] WDATA = 16'h0, RDATA, d, e, f;
	logic        MGMT_FRAME_ACCEPT, IRQ;
	int          bad_count = 0, cmp_count = 0, cyc = 0;
	mode_status uut (.CLK, .RESETN, .ADDR, .WDATA, .WR, .RD, .RDATA, .LINK_CODE_OK,
		.LP_RFAULT_IN, .FAR_FAULT, .MGMT_PREAMBLE_SEEN, .MGMT_FRAME_ACCEPT, .IRQ);
	// ----------------------------------------
	// Bus tasks
	// ----------------------------------------
	initial forever #4 CLK = ~CLK;
	task chk(string n, logic [15:0] x, y);
		cmp_count++;
		if (y !== x) begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", n, x, y);
		end
	endtask
	task wr(logic [4:0] a, logic [15:0] v);
		ADDR <= a;
		WDATA <= v;
		WR <= 1'b1;
		@(posedge CLK);
		WR <= 1'b0;
	endtask
	// Flags sampled mid-cycle, clear of the edge
	task rd(logic [4:0] a);
		ADDR <= a;
		RD <= 1'b1;
		@(posedge CLK);
		RD <= 1'b0;
		@(negedge CLK);
		d = RDATA;
		f = {14'h0, IRQ, MGMT_FRAME_ACCEPT};
		@(posedge CLK);
	endtask
	task waitc(int n);
		repeat (n) @(negedge CLK);
		f = {14'h0, IRQ, MGMT_FRAME_ACCEPT};
		@(posedge CLK);
	endtask
	task t_mirror;
		for (int i = 0; i < 16; i++) begin
			wr(5'h04, 16'h0001 | (16'(i) << 5));
			rd(5'h01);
			chk("caps", 16'(i), {12'h0, d[14:11]});
		end
		wr(5'h04, 16'h01e1);
	endtask
	task t_ign;
		ADDR <= 5'h01;
		RD <= 1'b1;
		@(posedge CLK);
		RD <= 1'b0;
		WR <= 1'b1;
		WDATA <= 16'hffff;
		@(negedge CLK);
		e = RDATA;
		@(posedge CLK);
		WR <= 1'b0;
		rd(5'h01);
		chk("status kept", e & 16'hffc0, d & 16'hffc0);
	endtask
	task t_pre;
		wr(5'h17, 16'h0020);
		rd(5'h01);
		chk("flag clear", 16'h0, d & 16'h0040);
		chk("accept off", 16'h0, f & 16'h1);
		MGMT_PREAMBLE_SEEN <= 1'b1;
		waitc(4);
		chk("accept seen", 16'h1, f & 16'h1);
		MGMT_PREAMBLE_SEEN <= 1'b0;
		wr(5'h17, 16'h0000);
		rd(5'h01);
		chk("flag set", 16'h0040, d & 16'h0040);
		chk("accept flag", 16'h1, f & 16'h1);
	endtask
	task t_an;
		wr(5'h19, 16'h0000);
		LINK_CODE_OK <= 1'b1;
		rd(5'h01);
		chk("done early", 16'h0, d & 16'h0020);
		waitc(140);
		chk("irq masked", 16'h0, f & 16'h2);
		rd(5'h01);
		chk("done", 16'h0020, d & 16'h0020);
		wr(5'h19, 16'h0001);
		waitc(2);
		chk("irq up", 16'h2, f & 16'h2);
		wr(5'h18, 16'h0001);
		waitc(2);
		chk("irq clear", 16'h0, f & 16'h2);
	endtask
	task t_rf;
		// Partner word is only captured while negotiating, so renegotiate
		LP_RFAULT_IN <= 1'b1;
		wr(5'h1a, 16'h0003);
		waitc(140);
		rd(5'h01);
		chk("partner fault", 16'h0010, d & 16'h0010);
		LP_RFAULT_IN <= 1'b0;
		wr(5'h1a, 16'h0000);
		waitc(4);
		rd(5'h01);
		rd(5'h01);
		chk("fault gone", 16'h0, d & 16'h0010);
		FAR_FAULT <= 1'b1;
		waitc(4);
		rd(5'h01);
		chk("far fault", 16'h0010, d & 16'h0010);
	endtask
	task summarize;
		$display("mismatches %0d comparisons %0d", bad_count, cmp_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// ----------------------------------------
	// Sequence and watchdog
	// ----------------------------------------
	initial begin
		repeat (5) @(posedge CLK);
		RESETN <= 1'b1;
		@(posedge CLK);
		rd(5'h01);
		chk("reset", 16'h7840, d);
		rd(5'h1f);
		chk("unmapped", 16'h0, d);
		t_mirror;
		t_ign;
		t_pre;
		t_an;
		t_rf;
		summarize;
	end
	always @(posedge CLK) begin
		cyc++;
		if (cyc == 3000) begin
			bad_count++;
			summarize;
		end
	end
endmodule // tb_top
